//--- design/flash_seq_pkg.sv
// Package: opcodes, frame positions, timings and carriers for the flash wipe/write sequencer
package flash_seq_pkg;
  // System clock rate
  localparam longint CLK_HZ = 40_000_000;
  localparam longint US_PER_S = 1_000_000;

  // Command opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_SMALL_WIPE = 8'h20;
  localparam logic [7:0] OP_HALF_WIPE = 8'h52;
  localparam logic [7:0] OP_FULL_WIPE = 8'hD8;
  localparam logic [7:0] OP_WHOLE_WIPE = 8'h60;
  localparam logic [7:0] OP_WHOLE_WIPE_ALT = 8'hC7;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_QUAD_READ_W = 8'hE7;

  // Bit positions inside a frame (bits received since chip select fell)
  localparam logic [5:0] POS_OPCODE = 6'h08;
  localparam logic [5:0] POS_ADDR = 6'h20;
  localparam logic [5:0] POS_INDICATOR = 6'h28;
  localparam logic [5:0] POS_SAT = 6'h28;
  localparam logic [2:0] STEP_SINGLE = 3'h1;
  localparam logic [2:0] STEP_QUAD = 3'h4;

  // Area sizes as address bit counts
  localparam logic [4:0] SPAN_SECTOR = 5'h0C;
  localparam logic [4:0] SPAN_HALF = 5'h0F;
  localparam logic [4:0] SPAN_FULL = 5'h10;
  localparam logic [4:0] SPAN_WHOLE = 5'h18;
  localparam logic [4:0] SPAN_PAGE = 5'h08;

  // Guard decode: level n covers the top 2^(n-1) 64K blocks, GUARD_ALL and up cover all
  localparam logic [3:0] GUARD_ALL = 4'h9;
  localparam logic [24:0] ARRAY_END = 25'h1000000;
  localparam logic [24:0] GUARD_UNIT = 25'h0010000;

  // Self-timed operation lengths in microseconds and in system clock cycles
  localparam longint SECTOR_WIPE_TIME_US = 30_000;
  localparam longint HALF_BLOCK_WIPE_TIME_US = 150_000;
  localparam longint FULL_BLOCK_WIPE_TIME_US = 300_000;
  localparam longint WHOLE_ARRAY_WIPE_TIME_US = 40_000_000;
  localparam longint PAGE_WRITE_TIME_US = 1_000;
  localparam int SECTOR_WIPE_CYC = int'((SECTOR_WIPE_TIME_US * CLK_HZ) / US_PER_S);
  localparam int HALF_BLOCK_WIPE_CYC = int'((HALF_BLOCK_WIPE_TIME_US * CLK_HZ) / US_PER_S);
  localparam int FULL_BLOCK_WIPE_CYC = int'((FULL_BLOCK_WIPE_TIME_US * CLK_HZ) / US_PER_S);
  localparam int WHOLE_ARRAY_WIPE_CYC = int'((WHOLE_ARRAY_WIPE_TIME_US * CLK_HZ) / US_PER_S);
  localparam int PAGE_WRITE_CYC = int'((PAGE_WRITE_TIME_US * CLK_HZ) / US_PER_S);

  // Wipe sizes
  typedef enum logic [1:0] {
    WIPE_SECTOR = 2'h0,
    WIPE_HALF = 2'h1,
    WIPE_FULL = 2'h2,
    WIPE_WHOLE = 2'h3
  } wipe_kind_t;

  // Sequencer states, Gray along idle, walk, timed
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_PROG = 2'b01,
    SEQ_TIMED = 2'b11
  } seq_state_t;

  // Summary of the last frame, held while chip select is high
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [5:0] pos;
    logic aligned;
    logic data_seen;
    logic cont_frame;
  } frame_info_t;

  // Request to the memory array core
  typedef struct packed {
    logic erase;
    wipe_kind_t kind;
    logic prog;
    logic [23:0] addr;
    logic [7:0] data;
  } array_req_t;
endpackage

//--- design/flash_link_rx.sv
// Link-clock receiver: frame shifting, page buffer and continuous-read tracking
`timescale 1ns/100ps
`default_nettype none
module flash_link_rx (
  // Link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] sio_in,
  // Reset and levels from the system clock side
  input wire logic sys_rst,
  input wire logic four_wire_command_mode,
  input wire logic array_busy_flag,
  // Frame summary, stable while chip select is high
  output flash_seq_pkg::frame_info_t frame,
  output logic cont_read_active,
  // Page buffer read port
  input wire logic [7:0] buf_rd_index,
  output logic [7:0] buf_rd_data,
  output logic buf_rd_valid
);
  logic [1:0] quad_sync;
  logic [1:0] busy_sync;
  logic in_frame;
  logic [31:0] shreg;
  logic [2:0] frac;
  logic [7:0] wptr;
  logic [7:0] page_buf [0:255];
  logic [255:0] page_mask;
  logic wide;
  logic [5:0] pos_now;
  logic [5:0] next_pos;
  logic [6:0] pos_sum;
  logic [2:0] step;
  logic [2:0] next_frac;
  logic [31:0] next_shreg;
  logic at_indicator;
  logic cont_capable;
  logic ind_toggles;
  logic buf_write;

  // Level synchronisers into the link clock
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      quad_sync <= 2'h0;
      busy_sync <= 2'h0;
    end else begin
      quad_sync <= {quad_sync[0], four_wire_command_mode};
      busy_sync <= {busy_sync[0], array_busy_flag};
    end
  end

  // Frame marker, ended by chip select itself
  always_ff @(posedge sclk or posedge cs_n or posedge sys_rst) begin
    if (sys_rst || cs_n) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // Bit position, lane width and shift value for this edge
  always_comb begin
    pos_now = in_frame ? frame.pos : (cont_read_active ? flash_seq_pkg::POS_OPCODE : 6'h00);
    wide = quad_sync[1] || !in_frame && cont_read_active ||
           (pos_now >= flash_seq_pkg::POS_OPCODE &&
            (frame.opcode == flash_seq_pkg::OP_QUAD_IO_READ || frame.opcode == flash_seq_pkg::OP_QUAD_READ_W));
    step = wide ? flash_seq_pkg::STEP_QUAD : flash_seq_pkg::STEP_SINGLE;
    next_shreg = wide ? {shreg[27:0], sio_in} : {shreg[30:0], sio_in[0]};
    pos_sum = {1'b0, pos_now} + {4'h0, step};
    next_pos = (pos_sum >= {1'b0, flash_seq_pkg::POS_SAT}) ? flash_seq_pkg::POS_SAT : pos_sum[5:0];
    next_frac = (in_frame ? frac : 3'h0) + step;
    at_indicator = pos_now < flash_seq_pkg::POS_INDICATOR && next_pos == flash_seq_pkg::POS_INDICATOR;
    cont_capable = quad_sync[1] ?
      (frame.opcode == flash_seq_pkg::OP_QUAD_IO_READ || frame.opcode == flash_seq_pkg::OP_FAST_READ) :
      (frame.opcode == flash_seq_pkg::OP_QUAD_IO_READ || frame.opcode == flash_seq_pkg::OP_QUAD_READ_W);
    ind_toggles = &(next_shreg[7:4] ^ next_shreg[3:0]);
    buf_write = in_frame && !frame.cont_frame && frame.opcode == flash_seq_pkg::OP_PAGE_WRITE &&
                pos_now >= flash_seq_pkg::POS_ADDR && next_frac == 3'h0 && !busy_sync[1];
  end

  // Shift register and frame summary
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      shreg <= 32'h0;
      frac <= 3'h0;
      frame <= '0;
    end else begin
      shreg <= next_shreg;
      frac <= next_frac;
      frame.pos <= next_pos;
      frame.aligned <= (next_frac == 3'h0);
      if (!in_frame) begin
        frame.cont_frame <= cont_read_active;
        frame.data_seen <= 1'b0;
      end else if (buf_write) begin
        frame.data_seen <= 1'b1;
      end
      if (pos_now < flash_seq_pkg::POS_OPCODE && next_pos == flash_seq_pkg::POS_OPCODE) begin
        frame.opcode <= next_shreg[7:0];
      end
      if (pos_now < flash_seq_pkg::POS_ADDR && next_pos == flash_seq_pkg::POS_ADDR) begin
        frame.addr <= next_shreg[23:0];
      end
    end
  end

  // Continuous-read flag survives chip select high
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      cont_read_active <= 1'b0;
    end else if (in_frame && at_indicator && (cont_capable || frame.cont_frame)) begin
      cont_read_active <= ind_toggles;
    end
  end

  // Write pointer and byte-present mask, restarted each frame
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr <= 8'h00;
      page_mask <= '0;
    end else if (!in_frame) begin
      page_mask <= '0;
    end else if (pos_now < flash_seq_pkg::POS_ADDR && next_pos == flash_seq_pkg::POS_ADDR) begin
      wptr <= next_shreg[7:0];
    end else if (buf_write) begin
      page_mask[wptr] <= 1'b1;
      wptr <= wptr + 8'h01;
    end
  end

  // Page buffer storage, later bytes overwrite earlier ones
  always_ff @(posedge sclk) begin
    if (buf_write) begin
      page_buf[wptr] <= next_shreg[7:0];
    end
  end

  assign buf_rd_data = page_buf[buf_rd_index];
  assign buf_rd_valid = page_mask[buf_rd_index];

  // Equal indicator pair always ends continuous-read
  a_cont_exit_pair: assert property (@(posedge sclk) disable iff (sys_rst)
    (in_frame && at_indicator && !ind_toggles) |=> !cont_read_active)
    else $error("continuous read kept after equal indicator pair");
endmodule
`default_nettype wire

//--- design/flash_wipe_write_seq.sv
// Flash wipe and page-write sequencer with continuous-read tracking
// Function
// - Toggling indicator nibbles enter continuous-read mode
// - Continuous read for four-wire EB/0B, single EB/E7
// - Two-line reads never enter continuous read
// - Continuous mode: next frame starts with address
// - Any equal indicator pair leaves continuous read
// - Small wipe clears 4K sector, address A23..A12
// - Address wipes need chip select after address
// - Opcode on one line or four lines
// - Self-timed cycle from chip select; busy, latch
// - Guarded target area blocks wipe or write
// - Half-block wipe clears addressed 32K block
// - Full-block wipe clears addressed 64K block
// - Whole wipe only with all guard bits zero
// - Page write keeps only the last 256 bytes
// - Page write starts at A7..A0, wraps inside
// - Page write ends only on byte boundary
`timescale 1ns/100ps
`default_nettype none
module flash_wipe_write_seq #(
  parameter int SECTOR_WIPE_CYCLES = flash_seq_pkg::SECTOR_WIPE_CYC,
  parameter int HALF_BLOCK_WIPE_CYCLES = flash_seq_pkg::HALF_BLOCK_WIPE_CYC,
  parameter int FULL_BLOCK_WIPE_CYCLES = flash_seq_pkg::FULL_BLOCK_WIPE_CYC,
  parameter int WHOLE_ARRAY_WIPE_CYCLES = flash_seq_pkg::WHOLE_ARRAY_WIPE_CYC,
  parameter int PAGE_WRITE_CYCLES = flash_seq_pkg::PAGE_WRITE_CYC
) (
  // System clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] sio_in,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe_n,
  // Configuration levels
  input wire logic four_wire_command_mode,
  input wire logic area_guard_bit3,
  input wire logic area_guard_bit2,
  input wire logic area_guard_bit1,
  input wire logic area_guard_bit0,
  // Status
  output logic array_busy_flag,
  output logic write_latch_flag,
  output logic cont_read_mode,
  output logic cmd_rejected,
  // Memory array core requests
  output flash_seq_pkg::array_req_t array_req
);
  flash_seq_pkg::frame_info_t frame;
  flash_seq_pkg::seq_state_t seq_state;
  flash_seq_pkg::wipe_kind_t kind;
  logic link_cont;
  logic [1:0] cs_sync;
  logic cs_prev;
  logic frame_end;
  logic [1:0] cont_sync;
  logic [3:0] area_guard;
  logic [7:0] walk;
  logic [15:0] page_base;
  logic [31:0] timer;
  logic [31:0] wipe_cycles;
  logic [7:0] buf_rd_data;
  logic buf_rd_valid;
  logic is_unlock;
  logic is_wipe;
  logic is_addr_wipe;
  logic is_page_write;
  logic well_formed;
  logic guarded;
  logic [4:0] span;
  logic start_wipe;
  logic start_prog;
  logic take_unlock;
  logic finish;

  // True when any byte of the area overlaps the guarded top of the array
  function automatic logic area_guarded(input logic [23:0] base, input logic [4:0] span_lsb,
                                        input logic [3:0] guard);
    logic [24:0] top;
    logic [24:0] limit;
    top = {1'b0, base | ((24'h000001 << span_lsb) - 24'h000001)};
    limit = flash_seq_pkg::ARRAY_END - (flash_seq_pkg::GUARD_UNIT << (guard - 4'h1));
    if (guard == 4'h0) begin
      return 1'b0;
    end
    if (guard >= flash_seq_pkg::GUARD_ALL) begin
      return 1'b1;
    end
    return top >= limit;
  endfunction

  assign area_guard = {area_guard_bit3, area_guard_bit2, area_guard_bit1, area_guard_bit0};

  // The device never drives the data lines in this block
  assign sio_out = 4'h0;
  assign sio_oe_n = 4'hF;

  // Link-clock side receiver
  flash_link_rx u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .sio_in(sio_in),
    .sys_rst(sys_rst),
    .four_wire_command_mode(four_wire_command_mode),
    .array_busy_flag(array_busy_flag),
    .frame(frame),
    .cont_read_active(link_cont),
    .buf_rd_index(walk),
    .buf_rd_data(buf_rd_data),
    .buf_rd_valid(buf_rd_valid)
  );

  // Chip select synchroniser and rising-edge detect
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_sync <= 2'b11;
      cs_prev <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], cs_n};
      cs_prev <= cs_sync[1];
    end
  end

  assign frame_end = cs_sync[1] && !cs_prev;

  // Continuous-read flag brought into the system clock
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cont_sync <= 2'h0;
    end else begin
      cont_sync <= {cont_sync[0], link_cont};
    end
  end

  assign cont_read_mode = cont_sync[1];

  // Decode of the finished frame
  always_comb begin
    is_unlock = frame.opcode == flash_seq_pkg::OP_WRITE_UNLOCK;
    is_addr_wipe = frame.opcode == flash_seq_pkg::OP_SMALL_WIPE ||
                   frame.opcode == flash_seq_pkg::OP_HALF_WIPE ||
                   frame.opcode == flash_seq_pkg::OP_FULL_WIPE;
    is_wipe = is_addr_wipe || frame.opcode == flash_seq_pkg::OP_WHOLE_WIPE ||
              frame.opcode == flash_seq_pkg::OP_WHOLE_WIPE_ALT;
    is_page_write = frame.opcode == flash_seq_pkg::OP_PAGE_WRITE;
    kind = flash_seq_pkg::WIPE_WHOLE;
    span = flash_seq_pkg::SPAN_WHOLE;
    wipe_cycles = 32'(WHOLE_ARRAY_WIPE_CYCLES);
    unique case (frame.opcode)
      flash_seq_pkg::OP_SMALL_WIPE: begin
        kind = flash_seq_pkg::WIPE_SECTOR;
        span = flash_seq_pkg::SPAN_SECTOR;
        wipe_cycles = 32'(SECTOR_WIPE_CYCLES);
      end
      flash_seq_pkg::OP_HALF_WIPE: begin
        kind = flash_seq_pkg::WIPE_HALF;
        span = flash_seq_pkg::SPAN_HALF;
        wipe_cycles = 32'(HALF_BLOCK_WIPE_CYCLES);
      end
      flash_seq_pkg::OP_FULL_WIPE: begin
        kind = flash_seq_pkg::WIPE_FULL;
        span = flash_seq_pkg::SPAN_FULL;
        wipe_cycles = 32'(FULL_BLOCK_WIPE_CYCLES);
      end
      flash_seq_pkg::OP_PAGE_WRITE: begin
        span = flash_seq_pkg::SPAN_PAGE;
        wipe_cycles = 32'(PAGE_WRITE_CYCLES);
      end
      default: begin
        kind = flash_seq_pkg::WIPE_WHOLE;
      end
    endcase
    // Exact frame length: lone opcode, opcode plus address, or whole data bytes
    if (is_addr_wipe) begin
      well_formed = frame.pos == flash_seq_pkg::POS_ADDR && frame.aligned;
    end else if (is_page_write) begin
      well_formed = frame.pos == flash_seq_pkg::POS_SAT && frame.aligned && frame.data_seen;
    end else begin
      well_formed = frame.pos == flash_seq_pkg::POS_OPCODE && frame.aligned;
    end
    guarded = area_guarded(is_addr_wipe || is_page_write ? frame.addr : 24'h000000, span, area_guard);
    take_unlock = frame_end && !frame.cont_frame && seq_state == flash_seq_pkg::SEQ_IDLE && is_unlock && well_formed;
    start_wipe = frame_end && !frame.cont_frame && seq_state == flash_seq_pkg::SEQ_IDLE && is_wipe &&
                 well_formed && write_latch_flag && !guarded;
    start_prog = frame_end && !frame.cont_frame && seq_state == flash_seq_pkg::SEQ_IDLE && is_page_write &&
                 well_formed && write_latch_flag && !guarded;
    finish = seq_state == flash_seq_pkg::SEQ_TIMED && timer == 32'h0;
  end

  // Sequencer state, walk index and cycle timer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_state <= flash_seq_pkg::SEQ_IDLE;
      timer <= 32'h0;
      walk <= 8'h00;
      page_base <= 16'h0000;
    end else begin
      unique case (seq_state)
        flash_seq_pkg::SEQ_IDLE: begin
          walk <= 8'h00;
          if (start_wipe) begin
            seq_state <= flash_seq_pkg::SEQ_TIMED;
            timer <= wipe_cycles;
          end else if (start_prog) begin
            seq_state <= flash_seq_pkg::SEQ_PROG;
            page_base <= frame.addr[23:8];
          end
        end
        flash_seq_pkg::SEQ_PROG: begin
          walk <= walk + 8'h01;
          if (walk == 8'hFF) begin
            seq_state <= flash_seq_pkg::SEQ_TIMED;
            timer <= 32'(PAGE_WRITE_CYCLES);
          end
        end
        flash_seq_pkg::SEQ_TIMED: begin
          if (timer == 32'h0) begin
            seq_state <= flash_seq_pkg::SEQ_IDLE;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        default: begin
          seq_state <= flash_seq_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Busy flag, set at chip select rise and held until the timed cycle ends
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      array_busy_flag <= 1'b0;
    end else if (start_wipe || start_prog) begin
      array_busy_flag <= 1'b1;
    end else if (finish) begin
      array_busy_flag <= 1'b0;
    end
  end

  // Write latch: set by write unlock, cleared at completion
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      write_latch_flag <= 1'b0;
    end else if (take_unlock) begin
      write_latch_flag <= 1'b1;
    end else if (finish) begin
      write_latch_flag <= 1'b0;
    end
  end

  // Rejection pulse for wipe or write frames that do not run
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_rejected <= 1'b0;
    end else begin
      cmd_rejected <= frame_end && !frame.cont_frame && (is_wipe || is_page_write) && !start_wipe && !start_prog;
    end
  end

  // Requests to the array core: one erase pulse per wipe, or one write per buffered byte for a page write
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      array_req <= '0;
    end else begin
      array_req.erase <= start_wipe;
      array_req.prog <= 1'b0;
      if (start_wipe) begin
        array_req.kind <= kind;
        array_req.addr <= frame.addr & ~((24'h000001 << span) - 24'h000001);
      end else if (seq_state == flash_seq_pkg::SEQ_PROG && buf_rd_valid) begin
        array_req.prog <= 1'b1;
        array_req.addr <= {page_base, walk};
        array_req.data <= buf_rd_data;
      end
    end
  end

  // A run can only start with the write latch already set
  a_latch_before_busy: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(array_busy_flag) |-> $past(write_latch_flag))
    else $error("busy rose without write latch");

  // A run starts only on a chip select rise
  a_busy_on_cs_rise: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(array_busy_flag) |-> $past(frame_end))
    else $error("busy rose without chip select rise");

  // Completion clears both flags together
  a_done_clears_latch: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(array_busy_flag) |-> !write_latch_flag && seq_state == flash_seq_pkg::SEQ_IDLE)
    else $error("write latch left set after completion");

  // Whole wipe with any guard bit set never runs
  a_whole_guarded: assert property (@(posedge mclk) disable iff (sys_rst)
    (frame_end && !array_busy_flag && area_guard != 4'h0 &&
     (frame.opcode == flash_seq_pkg::OP_WHOLE_WIPE || frame.opcode == flash_seq_pkg::OP_WHOLE_WIPE_ALT))
    |=> !array_busy_flag ##1 !array_req.erase)
    else $error("whole wipe ran while guarded");

  // Address wipe with wrong length is dropped
  a_wipe_exact_len: assert property (@(posedge mclk) disable iff (sys_rst)
    (frame_end && !array_busy_flag && is_addr_wipe && frame.pos != flash_seq_pkg::POS_ADDR)
    |=> !array_busy_flag && cmd_rejected)
    else $error("address wipe with wrong length accepted");

  // Page write ending mid-byte is dropped
  a_page_byte_end: assert property (@(posedge mclk) disable iff (sys_rst)
    (frame_end && !array_busy_flag && is_page_write && !frame.aligned) |=> !array_busy_flag)
    else $error("page write ending mid-byte accepted");

  // Sector erase address is sector aligned
  a_sector_base: assert property (@(posedge mclk) disable iff (sys_rst)
    (array_req.erase && array_req.kind == flash_seq_pkg::WIPE_SECTOR) |-> array_req.addr[11:0] == 12'h000)
    else $error("sector erase address not aligned");

  // Programmed bytes stay in the selected page
  a_prog_in_page: assert property (@(posedge mclk) disable iff (sys_rst)
    array_req.prog |-> array_req.addr[23:8] == page_base && array_busy_flag)
    else $error("page write left its page");

  // Frames without the latch leave busy untouched
  a_no_latch_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
    (frame_end && !write_latch_flag && !array_busy_flag) |=> !array_busy_flag)
    else $error("command ran without write latch");
endmodule
`default_nettype wire

//--- design/flash_link_rx_end.sv
// Spare design unit: holds no logic, only the implicit-net setting
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- tb/flash_host.sv
// Host model: drives frames onto the serial link
`timescale 1ns/100ps
`default_nettype none
module flash_host (
  // Link pins
  output logic sclk,
  output logic cs_n,
  output logic [3:0] sio_in
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sio_in = 4'h0;
  end
  // Sends n bits msb first; q[0] all on four lines, q[1] four lines after the opcode; clock stops between frames
  task automatic send(input logic [2111:0] b, input int n, input bit [1:0] q);
    int i;
    cs_n = 1'b0;
    for (i = n - 1; i >= 0; i = i - (q[0] || q[1] && i < n - 8 ? 4 : 1)) begin
      sio_in = q[0] || q[1] && i < n - 8 ? b[i-:4] : {~sio_in[3:1], b[i]};
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    sio_in = ~sio_in; // Released lines show no stale value
    #400;
  endtask
endmodule
`default_nettype wire

//--- tb/serial_flash_erase_program_xip_tb_top.sv
// Testbench: sequencer against a behavioural model
`timescale 1ns/100ps
`default_nettype none
module serial_flash_erase_program_xip_tb_top;
  logic mclk, sys_rst, quad, busy, latch, cont, rej, sclk, cs_n;
  logic [3:0] guard, sio_in, sio_out, sio_oe_n;
  logic [2111:0] f;
  logic [7:0] pb [256];
  logic [23:0] msk [4] = '{24'hFFF000, 24'hFF8000, 24'hFF0000, 24'h0};
  flash_seq_pkg::array_req_t array_req, exp_q [$], got_q [$];
  int err_count, checks_done, run, blen, rn, k, i, a;
  flash_host host (.sclk, .cs_n, .sio_in);
  flash_wipe_write_seq #(20, 40, 60, 80, 10) dut (.mclk, .sys_rst, .sclk, .cs_n, .sio_in, .sio_out, .sio_oe_n,
    .four_wire_command_mode(quad), .area_guard_bit3(guard[3]), .area_guard_bit2(guard[2]),
    .area_guard_bit1(guard[1]), .area_guard_bit0(guard[0]), .array_busy_flag(busy),
    .write_latch_flag(latch), .cont_read_mode(cont), .cmd_rejected(rej), .array_req);
  // Clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Records array requests, busy run lengths and refusals
  always @(negedge mclk) begin
    if (array_req.erase || array_req.prog) got_q.push_back({array_req.erase,
      array_req.erase ? array_req.kind : 2'h0, array_req.prog, array_req.addr, array_req.erase ? 8'h0 : array_req.data});
    if (busy) run++;
    else if (run > 0) begin
      blen = run;
      run = 0;
    end
    rn += rej;
  end
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Compares recorded requests with the model's
  task automatic drain();
    chk("requests", exp_q.size(), got_q.size());
    while (exp_q.size() > 0 && got_q.size() > 0) chk("request", exp_q.pop_front(), got_q.pop_front());
    exp_q = {};
    got_q = {};
  endtask
  task automatic summarize();
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait for the array to go idle
  task automatic idle();
    int t;
    for (t = 0; t < 4000 && busy !== 1'b0; t++) @(negedge mclk);
    if (t == 4000) begin
      chk("idle", 0, busy);
      summarize();
    end
    @(negedge mclk);
  endtask
  // Dummy frame lets the mode level settle in the link domain
  task automatic mode(input logic q);
    @(negedge mclk) quad = q;
    host.send(16'h0, 16, q);
  endtask
  initial begin
    quad = 1'b0;
    guard = 4'h0;
    sys_rst = 1'b1;
    a = $urandom(32'hA441BD2D);
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    // Every wipe size, alternating command modes
    for (k = 0; k < 4; k++) begin
      mode(k[0]);
      host.send(8'h06, 8, quad);
      chk("latch", 1, latch);
      a = $urandom & 32'h7FFFFF;
      if (k < 3) host.send({k == 0 ? 8'h20 : k == 1 ? 8'h52 : 8'hD8, a[23:0]}, 32, quad);
      else host.send(8'h60, 8, quad);
      exp_q.push_back({1'b1, k[1:0], 1'b0, a[23:0] & msk[k], 8'h0});
      idle();
      drain();
      chk("busy time", (k == 0 ? 20 : k * 20 + 20) + 1, blen);
      chk("latch", 0, latch);
    end
    // Refused frames: no unlock, odd lengths, guarded areas
    mode(0);
    for (k = 0; k < 5; k++) begin
      if (k > 0) host.send(8'h06, 8, 1'b0);
      @(negedge mclk) guard = k > 2 ? 4'h1 : 4'h0;
      i = rn;
      case (k)
        1: host.send(33'h041FFE246, 33, 1'b0);
        2: host.send(36'h02000000A, 36, 1'b0);
        4: host.send(8'hC7, 8, 1'b0);
        default: host.send(32'h20FFF123, 32, 1'b0);
      endcase
      chk("refused", i + 1, rn);
      chk("busy", 0, busy);
    end
    drain();
    // Page write of 258 bytes wraps and keeps the last 256
    @(negedge mclk) guard = 4'h0;
    mode(1);
    host.send(8'h06, 8, 1'b1);
    a = $urandom & 32'h7FFFFF;
    f = {8'h02, a[23:0]};
    for (i = 0; i < 258; i++) begin
      k = $urandom;
      f = {f[2103:0], k[7:0]};
      pb[(a + i) & 255] = k[7:0];
    end
    host.send(f, 2096, 1'b1);
    for (i = 0; i < 256; i++) exp_q.push_back({4'h1, a[23:8], i[7:0], pb[i]});
    idle();
    drain();
    chk("latch", 0, latch);
    // Continuous read: enter on both quad opcodes and single-mode E7h, stay, then leave
    for (k = 0; k < 3; k++) begin
      i = $urandom;
      if (k == 2) mode(0);
      host.send({k == 0 ? 8'hEB : k == 1 ? 8'h0B : 8'hE7, i[23:0], k ? 8'h0F : 8'hA5}, 40, {k == 2, k < 2});
      chk("cont", 1, cont);
      host.send({i[23:0], 8'h5A}, 32, 1'b1);
      chk("cont", 1, cont);
      host.send({i[23:0], k ? 8'hFF : 8'hAA}, 32, 1'b1);
      chk("cont", 0, cont);
    end
    // A two-line read with a toggling indicator never enters continuous read
    i = $urandom;
    host.send({8'hBB, i[23:0], 8'hA5}, 40, 1'b0);
    chk("cont", 0, cont);
    chk("pins", 8'hF0, {sio_oe_n, sio_out});
    summarize();
  end
endmodule
`default_nettype wire
